// >>> src/ifm_monitor.sv
// Purpose: input link clock frequency monitor with AXI4-Lite registers
// Assumes: link clock well below aclk/2; pins are asynchronous
// Notes:   frequency measured over a fixed gate window in MHz
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module ifm_monitor
   import ifm_pkg::*;
#(
   parameter int STBL0 = STBL0_CYC,
   parameter int STBL1 = STBL1_CYC,
   parameter int STBL2 = STBL2_CYC,
   parameter int STBL3 = STBL3_CYC
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic [ifm_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [ifm_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [ifm_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [ifm_pkg::DATA_W-1:0]     s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      link_clk,
   input  wire logic                      dual_pixel_mode,
   output logic                           phy_reset,
   output logic                           clk_valid,
   output logic                           irq
);

   import ifm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // registers and state
   logic [ADDR_W-1:0] awaddr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_got_q;
   logic              w_got_q;
   ifm_det_ctl_t      det_q;
   ifm_limits_t       lim_q;
   logic [7:0]        pix_rate_q;
   logic [EV_W-1:0]   stat_q;
   logic [EV_W-1:0]   stat_d;
   logic [EV_W-1:0]   mask_q;
   logic [1:0]        pins_s;
   logic              lclk_prev_q;
   logic              mode_prev_q;
   logic [7:0]        win_q;
   logic [7:0]        edges_q;
   logic [7:0]        freq_q;
   logic [STBL_W-1:0] stab_cnt_q;
   logic              stable_q;
   logic              meas_zero_q;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   ifm_sync #(
      .W (2)
   ) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({dual_pixel_mode, link_clk}),
      .sync_out (pins_s)
   );

   wire lclk_s   = pins_s[0];
   wire mode_s   = pins_s[1];
   wire lclk_rise = lclk_s & ~lclk_prev_q;
   wire mode_chg  = mode_s ^ mode_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // measurement and hysteresis
   wire       win_end  = (win_q == 8'(WINDOW_CYC - 1));
   wire [7:0] meas     = edges_q >> WINDOW_SHIFT;
   wire [7:0] diff     = (meas > freq_q) ? (meas - freq_q) : (freq_q - meas);
   wire       capture  = win_end & (diff > {5'h00, det_q.measure_hysteresis});
   wire [STBL_W-1:0] stab_lim =
        (det_q.stable_time_select == 2'h0) ? STBL_W'(STBL0 - 1) :
        (det_q.stable_time_select == 2'h1) ? STBL_W'(STBL1 - 1) :
        (det_q.stable_time_select == 2'h2) ? STBL_W'(STBL2 - 1) :
                                             STBL_W'(STBL3 - 1);
   wire       too_slow = freq_q < {2'h0, lim_q.low_freq_limit};
   wire       too_fast = freq_q > {1'h0, lim_q.high_freq_limit};
   wire       clk_ok   = det_q.clock_present_override |
                         (stable_q & ~too_slow & ~too_fast);
   wire [7:0] pix_now  = mode_s ? {freq_q[6:0], 1'b0} : freq_q;
   wire       phy_ev   = (capture | mode_chg) &
                         ~lim_q.phy_reset_on_change_disable;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lclk_prev_q <= 1'b0;
         mode_prev_q <= 1'b0;
         win_q       <= 8'h00;
         edges_q     <= 8'h00;
      end else begin
         lclk_prev_q <= lclk_s;
         mode_prev_q <= mode_s;
         win_q       <= win_end ? 8'h00 : win_q + 8'h01;
         if (win_end) begin
            edges_q <= {7'h00, lclk_rise};
         end else if (lclk_rise && edges_q != 8'hFF) begin
            edges_q <= edges_q + 8'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         freq_q      <= 8'h00;
         stab_cnt_q  <= '0;
         stable_q    <= 1'b0;
         meas_zero_q <= 1'b1;
      end else begin
         if (win_end) begin
            meas_zero_q <= (meas == 8'h00);
         end
         if (capture || mode_chg) begin
            if (capture) begin
               freq_q <= meas;
            end
            stab_cnt_q <= '0;
            stable_q   <= 1'b0;
         end else if (!stable_q) begin
            if (stab_cnt_q >= stab_lim) begin
               stable_q <= 1'b1;
            end else begin
               stab_cnt_q <= stab_cnt_q + STBL_W'(1);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pixel rate, phy reset, validity
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pix_rate_q <= PIX_RATE_RST;
         phy_reset  <= 1'b0;
         clk_valid  <= 1'b0;
      end else begin
         phy_reset <= phy_ev;
         clk_valid <= clk_ok;
         if (win_end) begin
            if (meas == 8'h00 && !det_q.clock_present_override) begin
               pix_rate_q <= pix_rate_q;
            end else if (clk_ok) begin
               pix_rate_q <= pix_now;
            end else begin
               pix_rate_q <= 8'h00;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register bus decode
   wire        wr_fire  = aw_got_q & w_got_q & ~s_axi_bvalid;
   wire [9:0]  wr_idx   = awaddr_q[11:2];
   wire        wr_det   = wr_fire & (wr_idx == IDX_DET_CTL) & wstrb_q[0];
   wire        wr_low   = wr_fire & (wr_idx == IDX_LOW_CTL) & wstrb_q[0];
   wire        wr_high  = wr_fire & (wr_idx == IDX_HIGH_CTL) & wstrb_q[0];
   wire        wr_mask  = wr_fire & (wr_idx == IDX_IRQ_MASK) & wstrb_q[0];
   wire        wr_map   = (wr_idx == IDX_DET_CTL) | (wr_idx == IDX_LOW_CTL) |
                          (wr_idx == IDX_HIGH_CTL) | (wr_idx == IDX_PIX_RATE) |
                          (wr_idx == IDX_IRQ_STAT) | (wr_idx == IDX_IRQ_MASK);
   wire        rd_fire  = s_axi_arvalid & s_axi_arready;
   wire [9:0]  rd_idx   = s_axi_araddr[11:2];
   logic [7:0] rd_byte;
   logic       rd_ok;

   always_comb begin
      rd_byte = 8'h00;
      rd_ok   = 1'b1;
      if (rd_idx == IDX_DET_CTL) begin
         rd_byte = {2'h0, det_q};
      end else if (rd_idx == IDX_LOW_CTL) begin
         rd_byte = {1'b0, lim_q.phy_reset_on_change_disable,
                    lim_q.low_freq_limit};
      end else if (rd_idx == IDX_HIGH_CTL) begin
         rd_byte = {1'b0, lim_q.high_freq_limit};
      end else if (rd_idx == IDX_PIX_RATE) begin
         rd_byte = pix_rate_q;
      end else if (rd_idx == IDX_IRQ_STAT) begin
         rd_byte = {4'h0, stat_q};
      end else if (rd_idx == IDX_IRQ_MASK) begin
         rd_byte = {4'h0, mask_q};
      end else begin
         rd_ok = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         awaddr_q      <= '0;
         wdata_q       <= '0;
         wstrb_q       <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q      <= s_axi_awaddr;
            aw_got_q      <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            w_got_q      <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         det_q  <= DET_CTL_RST;
         lim_q  <= {LOW_CTL_RST[LOW_RST_BIT:0], HIGH_CTL_RST[HIGH_LIM_MSB:0]};
         mask_q <= IRQ_MASK_RST;
      end else begin
         if (wr_det) begin
            det_q <= wdata_q[5:0];
         end
         if (wr_low) begin
            lim_q.phy_reset_on_change_disable <= wdata_q[LOW_RST_BIT];
            lim_q.low_freq_limit <= wdata_q[LOW_LIM_MSB:0];
         end
         if (wr_high) begin
            lim_q.high_freq_limit <= wdata_q[HIGH_LIM_MSB:0];
         end
         if (wr_mask) begin
            mask_q <= wdata_q[EV_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, rd_byte};
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status: read clears, new events win
   wire [EV_W-1:0] ev_set;
   wire            stat_clr = rd_fire & (rd_idx == IDX_IRQ_STAT);

   assign ev_set[EV_FREQ_CHG] = capture;
   assign ev_set[EV_CLK_UP]   = clk_ok & ~clk_valid;
   assign ev_set[EV_CLK_LOST] = ~clk_ok & clk_valid;
   assign ev_set[EV_MODE_CHG] = mode_chg;

   always_comb begin
      stat_d = stat_clr ? ev_set : (stat_q | ev_set);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= '0;
         irq    <= 1'b0;
      end else begin
         stat_q <= stat_d;
         irq    <= |(stat_d & mask_q);
      end
   end

endmodule

// >>> include/ifm_pkg.sv
// Purpose: shared constants and types of the input clock frequency monitor
// Assumes: 40 MHz aclk, 32-bit AXI4-Lite register access
// Notes:   register indices; byte address is four times the index
package ifm_pkg;

   ////////////////////////////////////////////////////////////////////////
   // bus geometry
   localparam int          ADDR_W        = 12;
   localparam int          DATA_W        = 32;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // register indices
   localparam logic [9:0]  IDX_DET_CTL   = 10'h05C;
   localparam logic [9:0]  IDX_LOW_CTL   = 10'h05D;
   localparam logic [9:0]  IDX_HIGH_CTL  = 10'h05E;
   localparam logic [9:0]  IDX_PIX_RATE  = 10'h05F;
   localparam logic [9:0]  IDX_IRQ_STAT  = 10'h070;
   localparam logic [9:0]  IDX_IRQ_MASK  = 10'h071;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int          LOW_RST_BIT   = 6;
   localparam int          LOW_LIM_MSB   = 5;
   localparam int          HIGH_LIM_MSB  = 6;
   localparam int          EV_FREQ_CHG   = 0;
   localparam int          EV_CLK_UP     = 1;
   localparam int          EV_CLK_LOST   = 2;
   localparam int          EV_MODE_CHG   = 3;
   localparam int          EV_W          = 4;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0]  LOW_CTL_RST   = 8'h06;
   localparam logic [7:0]  HIGH_CTL_RST  = 8'h44;
   localparam logic [7:0]  PIX_RATE_RST  = 8'h00;
   localparam logic [5:0]  DET_CTL_RST   = 6'h02;
   localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int          CLK_PERIOD_NS = 25;
   localparam int          WINDOW_NS     = 4000;
   localparam int          WINDOW_CYC    = WINDOW_NS / CLK_PERIOD_NS;
   localparam int          WINDOW_SHIFT  = 2;
   localparam int          STBL0_US      = 160;
   localparam int          STBL1_US      = 640;
   localparam int          STBL2_NS      = 1280000;
   localparam int          STBL3_NS      = 2550000;
   localparam int          STBL0_CYC     = (STBL0_US * 1000) / CLK_PERIOD_NS;
   localparam int          STBL1_CYC     = (STBL1_US * 1000) / CLK_PERIOD_NS;
   localparam int          STBL2_CYC     = STBL2_NS / CLK_PERIOD_NS;
   localparam int          STBL3_CYC     = STBL3_NS / CLK_PERIOD_NS;
   localparam int          STBL_W        = 17;

   ////////////////////////////////////////////////////////////////////////
   // detector control word and frequency limit fields
   typedef struct packed {
      logic       clock_present_override;
      logic [1:0] stable_time_select;
      logic [2:0] measure_hysteresis;
   } ifm_det_ctl_t;

   typedef struct packed {
      logic       phy_reset_on_change_disable;
      logic [5:0] low_freq_limit;
      logic [6:0] high_freq_limit;
   } ifm_limits_t;

endpackage

// >>> src/ifm_sync.sv
// Purpose: two-flop synchroniser for pin-level inputs
// Assumes: inputs are levels from outside the aclk domain
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module ifm_sync #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// >>> test/ifm_monitor_checker.sv
// Purpose: port checks for the link clock frequency monitor
// Assumes: bound to every ifm_monitor instance
// Notes:   mirrors the phy reset disable bit from bus writes
`timescale 1ns/1ps
module ifm_monitor_checker (
   input wire logic                       aclk,
   input wire logic                       aresetn,
   input wire logic [ifm_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic                       s_axi_awvalid,
   input wire logic                       s_axi_awready,
   input wire logic [ifm_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic                       s_axi_wvalid,
   input wire logic                       s_axi_wready,
   input wire logic [1:0]                 s_axi_bresp,
   input wire logic                       s_axi_bvalid,
   input wire logic                       s_axi_bready,
   input wire logic                       s_axi_arvalid,
   input wire logic                       s_axi_arready,
   input wire logic [ifm_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic                       s_axi_rvalid,
   input wire logic                       s_axi_rready,
   input wire logic                       phy_reset,
   input wire logic                       clk_valid,
   input wire logic                       irq
);
   import ifm_pkg::*;
   logic dis_q;
   logic dis_d;
   wire  wr_both = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   wire  wr_low  = wr_both && (s_axi_awaddr == {IDX_LOW_CTL, 2'h0});
   wire  rd_take = s_axi_arvalid & s_axi_arready;
   assign dis_d = wr_low ? s_axi_wdata[LOW_RST_BIT] : dis_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) dis_q <= 1'b0;
      else dis_q <= dis_d;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////
   property p_phy_pulse; phy_reset |=> !phy_reset; endproperty
   a_phy_pulse: assert property (p_phy_pulse)
      else $error("phy reset wider than one cycle");
   property p_phy_off; dis_q |-> ##2 !phy_reset; endproperty
   a_phy_off: assert property (p_phy_off)
      else $error("phy reset while disabled");
   property p_b_hold; s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_r_hold; s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");
   property p_w_block; wr_both |=> !s_axi_awready && !s_axi_wready;
   endproperty
   a_w_block: assert property (p_w_block)
      else $error("write channels not blocked");
   property p_b_answer; wr_both |-> ##2 s_axi_bvalid; endproperty
   a_b_answer: assert property (p_b_answer)
      else $error("write response late");
   property p_r_answer; rd_take |=> !s_axi_arready && s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer)
      else $error("read answer late");
   property p_rst_vals; $rose(aresetn) |-> !clk_valid && !irq
      && !phy_reset && !s_axi_rvalid && !s_axi_bvalid; endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("outputs not quiet after reset");
endmodule

bind ifm_monitor ifm_monitor_checker i_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .phy_reset(phy_reset),
   .clk_valid(clk_valid), .irq(irq));

// >>> test/ifm_link_src.sv
// Purpose: video source model driving link clock and pixel mode pins
// Assumes: link clock runs only while run is high, idles low otherwise
// Notes:   3 ns offset keeps link edges clear of aclk edges
`timescale 1ns/1ps
module ifm_link_src (
   input  wire logic run,
   input  wire logic dual_req,
   output logic      link_clk,
   output logic      dual_pixel_mode
);
   assign dual_pixel_mode = dual_req;
   initial begin
      link_clk = 1'b0;
      #3;
      forever begin
         if (run) begin
            #100 link_clk = 1'b1;
            #100 link_clk = 1'b0;
         end
         else
            #25;
      end
   end
endmodule

// >>> test/test_ifm_monitor.sv
// Purpose: self-checking bench of the link clock frequency monitor
// Assumes: stability times shortened to 50 cycles
// Notes:   5 MHz link clock gives a measured value of 5
`timescale 1ns/1ps
module test_ifm_monitor;
   import ifm_pkg::*;
   typedef struct packed {logic [7:0] d; logic [7:0] m; logic [1:0] r;} ifm_exp_t;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, stbl;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic        phy_reset, clk_valid, run, dual_req, link_clk, dual_mode;
   logic [5:0]  lo;
   int          failures, check_count, pulses, p0, seed_v;
   ifm_exp_t    rq[$];
   ifm_exp_t    re;
   logic [1:0]  bq[$];

   ifm_monitor #(.STBL0(50), .STBL1(50), .STBL2(50), .STBL3(50)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_rresp(rresp),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link_clk(link_clk), .phy_reset(phy_reset),
      .dual_pixel_mode(dual_mode), .clk_valid(clk_valid), .irq(irq));
   ifm_link_src i_src (.run(run), .dual_req(dual_req),
      .link_clk(link_clk), .dual_pixel_mode(dual_mode));

   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check_val(string name, logic [7:0] e, logic [7:0] s);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", name, e, s);
      end
   endtask
   task automatic axi_wr(logic [9:0] idx, logic [7:0] d, logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      bq.push_back(r);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 100);
      bready <= 1'b0;
      if (n >= 100) failures++;
      if (n >= 100) print_verdict();
   endtask
   task automatic axi_rd(logic [9:0] idx, logic [7:0] d, logic [7:0] m,
                         logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      rq.push_back('{d, m, r});
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 100);
      rready <= 1'b0;
      if (n >= 100) failures++;
      if (n >= 100) print_verdict();
   endtask
   task automatic wait_valid(logic e);
      int n;
      n = 0;
      while (clk_valid !== e && n < 3000) begin
         @(posedge aclk);
         n++;
      end
      check_val("clk_valid", {7'h00, e}, {7'h00, clk_valid});
      if (n >= 3000) print_verdict();
   endtask
   task automatic settle;
      repeat (800) @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
         re = rq.pop_front();
         check_val("rdata", re.d & re.m, rdata[7:0] & re.m);
         check_val("rresp", {6'h00, re.r}, {6'h00, rresp});
      end
      if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
         check_val("bresp", {6'h00, bq.pop_front()}, {6'h00, bresp});
      if (phy_reset === 1'b1) pulses++;
   end
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, run, dual_req} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      {failures, check_count, pulses} = '0;
      seed_v = $urandom(92);
      stbl = 2'($urandom % 4);
      lo = 6'(1 + $urandom % 5);
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(IDX_LOW_CTL, LOW_CTL_RST, 8'hFF, RESP_OKAY);
      axi_rd(IDX_HIGH_CTL, HIGH_CTL_RST, 8'hFF, RESP_OKAY);
      axi_rd(IDX_PIX_RATE, PIX_RATE_RST, 8'hFF, RESP_OKAY);
      axi_rd(IDX_DET_CTL, {2'h0, DET_CTL_RST}, 8'hFF, RESP_OKAY);
      axi_rd(IDX_IRQ_MASK, {4'h0, IRQ_MASK_RST}, 8'hFF, RESP_OKAY);
      axi_rd(10'h3FF, 8'h00, 8'hFF, RESP_SLVERR);
      axi_wr(10'h3FF, 8'h55, RESP_SLVERR);
      axi_wr(IDX_PIX_RATE, 8'hFF, RESP_OKAY);
      axi_rd(IDX_PIX_RATE, 8'h00, 8'hFF, RESP_OKAY);
      axi_wr(IDX_HIGH_CTL, 8'hFF, RESP_OKAY);
      axi_rd(IDX_HIGH_CTL, 8'h7F, 8'hFF, RESP_OKAY);
      axi_wr(IDX_HIGH_CTL, HIGH_CTL_RST, RESP_OKAY);
      $display("test registers done");
      run <= 1'b1;
      settle();
      wait_valid(1'b0);
      axi_rd(IDX_PIX_RATE, 8'h00, 8'hFF, RESP_OKAY);
      check_val("phy pulses", 8'h01, {7'h00, pulses > 0});
      $display("test slow clock done");
      // zero hysteresis: a partial start-up window must not pin the value
      axi_wr(IDX_DET_CTL, {3'h0, stbl, 3'h0}, RESP_OKAY);
      axi_wr(IDX_LOW_CTL, {2'h0, lo}, RESP_OKAY);
      wait_valid(1'b1);
      // pixel rate follows only at the next window end
      settle();
      axi_rd(IDX_PIX_RATE, 8'h05, 8'hFF, RESP_OKAY);
      axi_rd(IDX_IRQ_STAT, 8'h00, 8'h00, RESP_OKAY);
      axi_wr(IDX_LOW_CTL, {2'h1, lo}, RESP_OKAY);
      p0 = pulses;
      dual_req <= 1'b1;
      settle();
      wait_valid(1'b1);
      check_val("phy pulses", 8'(p0), 8'(pulses));
      check_val("irq", 8'h00, {7'h00, irq});
      axi_rd(IDX_PIX_RATE, 8'h0A, 8'hFF, RESP_OKAY);
      axi_wr(IDX_IRQ_MASK, 8'h08, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check_val("irq", 8'h01, {7'h00, irq});
      axi_rd(IDX_IRQ_STAT, 8'h08, 8'h08, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check_val("irq", 8'h00, {7'h00, irq});
      $display("test dual mode and interrupt done");
      run <= 1'b0;
      settle();
      axi_rd(IDX_PIX_RATE, 8'h0A, 8'hFF, RESP_OKAY);
      $display("test removal done");
      run <= 1'b1;
      axi_wr(IDX_HIGH_CTL, 8'h04, RESP_OKAY);
      settle();
      wait_valid(1'b0);
      axi_rd(IDX_PIX_RATE, 8'h00, 8'hFF, RESP_OKAY);
      axi_wr(IDX_DET_CTL, {3'h1, stbl, 3'h2}, RESP_OKAY);
      wait_valid(1'b1);
      settle();
      axi_rd(IDX_PIX_RATE, 8'h0A, 8'hFF, RESP_OKAY);
      $display("test limits and override done");
      print_verdict();
   end
endmodule
